// *** rtl/sdipof_formatter.sv ***
// Parallel output formatter: AHB-Lite control on clk_i, output bus on pclk_i
// Assumes recovered words arrive on pclk_i; pclk_i unrelated to clk_i
// Operation
// - Width control bit alone picks mux or demux
// - Wide video: chroma low, luma high; 3G two/one
// - Narrow SD/HD: interleaved upper half, lower zero
// - Narrow 3G: streams interleaved upper, lower zero
// - Bypass wide: raw data both halves
// - Bypass narrow: raw upper, lower zero
// - Transport, narrow SD only: bit19 error, bit18 sync, byte; otherwise all zero
// - Software may swap 3G stream positions
// - Automatic mode uses detected rate code
// - Rate code bit0 SD, else bit1 3G/HD
// - Output bus changes on pixel clock rising edge
// - Error flag on disparity or illegal code
// - Sync flag on comma character
`include "sdipof_regs_regs.svh"
module sdipof_formatter (
   input  wire logic                     clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     hsel_i,
   input  wire logic [31:0]              haddr_i,
   input  wire logic [1:0]               htrans_i,
   input  wire logic                     hwrite_i,
   input  wire logic [2:0]               hsize_i,
   input  wire logic [31:0]              hwdata_i,
   input  wire logic                     hready_i,
   output logic                          hreadyout_o,
   output logic                          hresp_o,
   output logic [31:0]                   hrdata_o,
   input  wire logic                     pclk_i,
   input  wire sdipof_pkg::sdipof_video_s video_i,
   input  wire logic                     trs_i,
   input  wire logic [1:0]               detected_rate_code_i,
   input  wire sdipof_pkg::sdipof_asi_s  asi_i,
   output logic [19:0]                   dout_o
);
   sdipof_pkg::sdipof_bus_s  b;
   sdipof_pkg::sdipof_bus_s  next_b;
   sdipof_pkg::sdipof_link_s l;
   sdipof_pkg::sdipof_link_s next_l;
   sdipof_pkg::sdipof_ctrl_s c;
   sdipof_pkg::sdipof_rate_e rate;
   logic [1:0]               eff_code;
   logic                     smpte;
   logic                     sel_second;
   logic [9:0]               s_one;
   logic [9:0]               s_two;
   logic [9:0]               first_w;
   logic [9:0]               second_w;

   // Rate code decode
   function automatic sdipof_pkg::sdipof_rate_e rate_of(input logic [1:0] code);
      if (code[0]) begin
         rate_of = sdipof_pkg::SDIPOF_SD;
      end else if (code[1]) begin
         rate_of = sdipof_pkg::SDIPOF_G3;
      end else begin
         rate_of = sdipof_pkg::SDIPOF_HD;
      end
   endfunction

   // Register read mux
   function automatic logic [31:0] reg_read(input logic [7:0] addr,
                                            input sdipof_pkg::sdipof_ctrl_s ctl,
                                            input logic [3:0] st);
      if (addr == `SDIPOF_OFF_CTRL) begin
         reg_read = {25'h000_0000, ctl};
      end else if (addr == `SDIPOF_OFF_STAT) begin
         reg_read = {28'h000_0000, st};
      end else begin
         reg_read = 32'h0000_0000;
      end
   endfunction

   // Bus side: zero-wait slave, status crossing in
   always_comb begin
      next_b = b;
      next_b.st1 = {l.eff, l.det};
      next_b.st2 = b.st1;
      next_b.ready = 1'b1;
      next_b.resp = 1'b0;
      if (b.wr_pend) begin
         next_b.wr_pend = 1'b0;
         if (b.wr_addr == `SDIPOF_OFF_CTRL) begin
            next_b.ctrl = sdipof_pkg::sdipof_ctrl_s'(hwdata_i[`SDIPOF_CTRL_W-1:0]);
         end
      end
      if (hsel_i && hready_i && htrans_i[`SDIPOF_HTRANS_NSQ]) begin
         if (hwrite_i) begin
            next_b.wr_pend = 1'b1;
            next_b.wr_addr = haddr_i[7:0];
         end else begin
            next_b.rdata = reg_read(haddr_i[7:0], next_b.ctrl, b.st2);
         end
      end
      if (reset_i) begin
         next_b.ctrl = `SDIPOF_CTRL_RST;
         next_b.rdata = 32'h0000_0000;
         next_b.wr_pend = 1'b0;
         next_b.wr_addr = 8'h00;
         next_b.st1 = 4'h0;
         next_b.st2 = 4'h0;
      end
   end

   // Bus state register
   always_ff @(posedge clk_i) begin
      b <= next_b;
   end

   assign hreadyout_o = b.ready;
   assign hresp_o = b.resp;
   assign hrdata_o = b.rdata;

   // Link-side mode decode from synchronised control
   assign c = l.cs2;
   assign eff_code = c.auto ? detected_rate_code_i : {c.rate1, c.rate0};
   assign rate = rate_of(eff_code);
   assign smpte = c.proc & ~c.asi;
   assign sel_second = l.phase & ~trs_i;
   assign s_one = c.swap ? video_i.b : video_i.a;
   assign s_two = c.swap ? video_i.a : video_i.b;
   assign first_w = (rate == sdipof_pkg::SDIPOF_G3) ? s_one : video_i.b;
   assign second_w = (rate == sdipof_pkg::SDIPOF_G3) ? s_two : video_i.a;

   // Link side: output word formation
   always_comb begin
      next_l = l;
      next_l.rst1 = reset_i;
      next_l.rst2 = l.rst1;
      next_l.cs1 = b.ctrl;
      next_l.cs2 = l.cs1;
      next_l.det = detected_rate_code_i;
      next_l.eff = eff_code;
      next_l.phase = 1'b0;
      if (smpte) begin
         if (c.width) begin
            if (rate == sdipof_pkg::SDIPOF_G3) begin
               next_l.dout = {s_one, s_two};
            end else begin
               next_l.dout = {video_i.a, video_i.b};
            end
         end else begin
            next_l.dout = {sel_second ? second_w : first_w, `SDIPOF_HALF_ZERO};
            next_l.phase = ~sel_second;
         end
      end else if (c.asi) begin
         if (!c.width && rate == sdipof_pkg::SDIPOF_SD) begin
            next_l.dout = {asi_i.disp_err | asi_i.illegal,
                           asi_i.kchar && asi_i.data == `SDIPOF_K28_5,
                           asi_i.data, `SDIPOF_HALF_ZERO};
         end else begin
            next_l.dout = 20'h0_0000;
         end
      end else if (c.width) begin
         next_l.dout = {video_i.a, video_i.b};
      end else begin
         next_l.dout = {video_i.a, `SDIPOF_HALF_ZERO};
      end
      if (l.rst2) begin
         next_l.cs1 = `SDIPOF_CTRL_RST;
         next_l.cs2 = `SDIPOF_CTRL_RST;
         next_l.det = 2'h0;
         next_l.eff = 2'h0;
         next_l.phase = 1'b0;
         next_l.dout = 20'h0_0000;
      end
   end

   // Link state register, rising edge only
   always_ff @(posedge pclk_i) begin
      l <= next_l;
   end

   assign dout_o = l.dout;

   // Mux start and follow-on steps
   sequence s_trs_start;
      smpte && !c.width && rate != sdipof_pkg::SDIPOF_G3 && trs_i;
   endsequence
   sequence s_follow;
      smpte && !c.width && rate != sdipof_pkg::SDIPOF_G3 && !trs_i;
   endsequence
   sequence s_g3_start;
      smpte && !c.width && rate == sdipof_pkg::SDIPOF_G3 && trs_i;
   endsequence

   a_chroma_first: assert property (@(posedge pclk_i) disable iff (l.rst2)
      s_trs_start |=> dout_o[19:10] == $past(video_i.b) && dout_o[9:0] == 10'h000)
      else $error("multiplexed output did not start with chroma");
   a_luma_follows: assert property (@(posedge pclk_i) disable iff (l.rst2)
      s_trs_start ##1 s_follow |=> dout_o[19:10] == $past(video_i.a) && dout_o[9:0] == 10'h000)
      else $error("multiplexed luma word missing");
   a_g3_stream_order: assert property (@(posedge pclk_i) disable iff (l.rst2)
      s_g3_start |=> dout_o[19:10] == $past(s_one) ##0 dout_o[9:0] == 10'h000)
      else $error("3G narrow output not stream one first");
   a_demux_layout: assert property (@(posedge pclk_i) disable iff (l.rst2)
      (smpte && c.width && rate != sdipof_pkg::SDIPOF_G3)
      |=> dout_o == {$past(video_i.a), $past(video_i.b)})
      else $error("demultiplexed layout wrong");
   a_g3_swap: assert property (@(posedge pclk_i) disable iff (l.rst2)
      (smpte && c.width && rate == sdipof_pkg::SDIPOF_G3 && c.swap)
      |=> dout_o == {$past(video_i.b), $past(video_i.a)})
      else $error("3G stream swap not applied");
   a_bypass_wide: assert property (@(posedge pclk_i) disable iff (l.rst2)
      (!c.proc && !c.asi && c.width) |=> dout_o == {$past(video_i.a), $past(video_i.b)})
      else $error("raw wide output wrong");
   a_bypass_narrow: assert property (@(posedge pclk_i) disable iff (l.rst2)
      (!c.proc && !c.asi && !c.width) |=> dout_o[9:0] == 10'h000
                                         && dout_o[19:10] == $past(video_i.a))
      else $error("raw narrow output wrong");
   a_asi_flags: assert property (@(posedge pclk_i) disable iff (l.rst2)
      (!c.proc && c.asi && !c.width && rate == sdipof_pkg::SDIPOF_SD
       && (asi_i.disp_err || asi_i.illegal)) |=> dout_o[19] && dout_o[17:10] == $past(asi_i.data))
      else $error("transport error flag missing");
   a_asi_sync: assert property (@(posedge pclk_i) disable iff (l.rst2)
      (!c.proc && c.asi && !c.width && rate == sdipof_pkg::SDIPOF_SD)
      |=> dout_o[18] == ($past(asi_i.kchar) && $past(asi_i.data) == `SDIPOF_K28_5))
      else $error("transport sync flag wrong");
   a_auto_rate: assert property (@(posedge pclk_i) disable iff (l.rst2)
      c.auto |=> l.eff == $past(detected_rate_code_i))
      else $error("automatic mode ignored detected rate");
   a_rate_decode: assert property (@(posedge pclk_i) disable iff (l.rst2)
      eff_code[0] |-> rate == sdipof_pkg::SDIPOF_SD)
      else $error("rate bit0 not decoded as SD");

   // Rate selection and wide 3G layout
   a_manual_rate: assert property (@(posedge pclk_i) disable iff (l.rst2)
      !c.auto |=> l.eff == $past({c.rate1, c.rate0}))
      else $error("manual mode ignored rate choice bits");
   a_g3_demux: assert property (@(posedge pclk_i) disable iff (l.rst2)
      (smpte && c.width && rate == sdipof_pkg::SDIPOF_G3 && !c.swap)
      |=> dout_o == {$past(video_i.a), $past(video_i.b)})
      else $error("3G wide output not stream one high");

   // Narrow video steps: any word, and the 3G word after the first
   sequence s_narrow_video;
      smpte && !c.width;
   endsequence
   sequence s_g3_follow;
      smpte && !c.width && rate == sdipof_pkg::SDIPOF_G3 && !trs_i;
   endsequence

   a_narrow_low_zero: assert property (@(posedge pclk_i) disable iff (l.rst2)
      s_narrow_video |=> dout_o[9:0] == `SDIPOF_HALF_ZERO)
      else $error("narrow video lower half not zero");
   a_g3_second: assert property (@(posedge pclk_i) disable iff (l.rst2)
      s_g3_start ##1 s_g3_follow |=> dout_o[19:10] == $past(s_two))
      else $error("3G narrow output second word not stream two");

   // Transport conditions
   sequence s_asi_legal;
      !c.proc && c.asi && !c.width && rate == sdipof_pkg::SDIPOF_SD;
   endsequence
   sequence s_asi_clean_word;
      !asi_i.disp_err && !asi_i.illegal;
   endsequence

   a_asi_byte: assert property (@(posedge pclk_i) disable iff (l.rst2)
      s_asi_legal |=> dout_o[17:10] == $past(asi_i.data)
                      && dout_o[9:0] == `SDIPOF_HALF_ZERO)
      else $error("transport byte misplaced");
   a_asi_clean: assert property (@(posedge pclk_i) disable iff (l.rst2)
      s_asi_legal ##0 s_asi_clean_word |=> !dout_o[19])
      else $error("transport error flag without error");
   a_asi_refused: assert property (@(posedge pclk_i) disable iff (l.rst2)
      (c.asi && (c.width || rate != sdipof_pkg::SDIPOF_SD))
      |=> dout_o == 20'h0_0000)
      else $error("transport output not blanked outside narrow SD");

   // Link reset clears the output bus
   a_link_reset: assert property (@(posedge pclk_i)
      l.rst2 |=> dout_o == 20'h0_0000)
      else $error("output bus not cleared by reset");

   // Register bus steps: address phase, then data phase
   sequence s_ctrl_wr_addr;
      hsel_i && hready_i && htrans_i[`SDIPOF_HTRANS_NSQ] && hwrite_i
         && haddr_i[7:0] == `SDIPOF_OFF_CTRL;
   endsequence
   sequence s_ctrl_rd_addr;
      hsel_i && hready_i && htrans_i[`SDIPOF_HTRANS_NSQ] && !hwrite_i && !b.wr_pend
         && haddr_i[7:0] == `SDIPOF_OFF_CTRL;
   endsequence
   sequence s_data_phase;
      hready_i;
   endsequence

   a_bus_okay: assert property (@(posedge clk_i) disable iff (reset_i)
      hreadyout_o && !hresp_o)
      else $error("bus slave not ready or not OKAY");
   a_ctrl_reset: assert property (@(posedge clk_i)
      reset_i |=> b.ctrl == `SDIPOF_CTRL_RST)
      else $error("control register not reset");
   a_ctrl_write: assert property (@(posedge clk_i) disable iff (reset_i)
      s_ctrl_wr_addr ##1 s_data_phase |=> b.ctrl == $past(hwdata_i[`SDIPOF_CTRL_W-1:0]))
      else $error("control write did not land");
   a_ctrl_readback: assert property (@(posedge clk_i) disable iff (reset_i)
      s_ctrl_rd_addr |=> hrdata_o == {25'h000_0000, $past(b.ctrl)})
      else $error("control read data wrong");
endmodule

// *** shared/sdipof_pkg.sv ***
// Types shared by the output formatter
// Assumes nothing beyond a SystemVerilog compiler
package sdipof_pkg;
   // Control bits, bit 0 at the bottom
   typedef struct packed {
      logic swap;     // Exchange 3G streams
      logic auto;     // automatic_rate_mode
      logic asi;      // Transport byte mode
      logic proc;     // video_processing_enable_n_bypass
      logic rate1;    // rate_choice_bit1
      logic rate0;    // rate_choice_bit0
      logic width;    // bus_width_select
   } sdipof_ctrl_s;
   typedef enum logic [2:0] {
      SDIPOF_SD = 3'h1,
      SDIPOF_HD = 3'h2,
      SDIPOF_G3 = 3'h4
   } sdipof_rate_e;
   typedef struct packed {
      logic [9:0] a;  // Luma or stream one or raw high
      logic [9:0] b;  // Chroma or stream two or raw low
   } sdipof_video_s;
   typedef struct packed {
      logic       disp_err;
      logic       illegal;
      logic       kchar;
      logic [7:0] data;
   } sdipof_asi_s;
   typedef struct packed {
      sdipof_ctrl_s ctrl;
      logic [31:0]  rdata;
      logic         wr_pend;
      logic [7:0]   wr_addr;
      logic         ready;
      logic         resp;
      logic [3:0]   st1;
      logic [3:0]   st2;
   } sdipof_bus_s;
   typedef struct packed {
      logic         rst1;
      logic         rst2;
      sdipof_ctrl_s cs1;
      sdipof_ctrl_s cs2;
      logic [1:0]   det;
      logic [1:0]   eff;
      logic         phase;
      logic [19:0]  dout;
   } sdipof_link_s;
endpackage

// *** shared/sdipof_regs_regs.svh ***
// Register offsets, field positions, reset values and codes of the output formatter
// Assumes inclusion by bare name from design files
`ifndef SDIPOF_REGS_REGS_SVH
`define SDIPOF_REGS_REGS_SVH
`define SDIPOF_OFF_CTRL   8'h00
`define SDIPOF_OFF_STAT   8'h04
`define SDIPOF_CTRL_W     7
`define SDIPOF_CTRL_RST   7'h29
`define SDIPOF_HTRANS_NSQ 1
`define SDIPOF_K28_5      8'hBC
`define SDIPOF_HALF_W     10
`define SDIPOF_HALF_ZERO  10'h000
`endif

// *** tb/sdipof_formatter_tb.sv ***
// Self-checking bench of the output formatter
// Assumes AHB-Lite zero-wait slave and a 125 ns pixel clock
module sdipof_formatter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [19:0] V  = 20'hA_955A;
   localparam logic [19:0] SW = 20'h5_6AA5;
   localparam logic [19:0] NA = 20'hA_9400;
   localparam logic [19:0] NB = 20'h5_6800;
   logic                      clk_i   = 1'b0;
   logic                      pclk_i  = 1'b0;
   logic                      reset_i = 1'b1;
   logic [31:0]               haddr   = 32'h0000_0000;
   logic [31:0]               hwdata  = 32'h0000_0000;
   logic [1:0]                htrans  = 2'h0;
   logic                      hwrite  = 1'b0;
   logic                      trs     = 1'b0;
   logic [1:0]                det     = 2'h0;
   sdipof_pkg::sdipof_video_s video   = 20'h0_0000;
   sdipof_pkg::sdipof_asi_s   asi     = 11'h000;
   logic                      hreadyout;
   logic                      hresp;
   logic [31:0]               hrdata;
   logic [19:0]               dout;
   logic [19:0]               word;
   int                        n_errors   = 0;
   int                        num_checks = 0;
   // Bus clock and unrelated pixel clock
   always #20 clk_i = ~clk_i;
   always #62.5 pclk_i = ~pclk_i;
   sdipof_formatter dut (
      .clk_i(clk_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
      .pclk_i(pclk_i), .video_i(video), .trs_i(trs), .detected_rate_code_i(det),
      .asi_i(asi), .dout_o(dout));
   sdipof_rx_model rx (.pclk_i(pclk_i), .dout_i(dout), .word_o(word));
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single AHB-Lite transfer, waiting on hready in both phases
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge clk_i);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk_i); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_i); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // Control write, then time for the crossing
   task automatic setc(input logic [6:0] c);
      logic [31:0] rd;
      xfer(1'b1, 32'h0000_0000, {25'h000_0000, c}, rd);
      repeat (6) @(posedge pclk_i);
   endtask
   task automatic drive(input logic [19:0] v, input logic [10:0] a, input logic [19:0] e);
      @(posedge pclk_i);
      video <= v;
      asi <= a;
      repeat (4) @(posedge pclk_i);
      #1;
      chk({12'h000, word}, {12'h000, e});
   endtask
   // Interleaved pair after a timing reference
   task automatic mux(input logic [19:0] f, input logic [19:0] s);
      @(posedge pclk_i);
      video <= V;
      trs <= 1'b1;
      @(posedge pclk_i);
      trs <= 1'b0;
      @(posedge pclk_i);
      #1;
      chk({12'h000, word}, {12'h000, f});
      @(posedge pclk_i);
      #1;
      chk({12'h000, word}, {12'h000, s});
   endtask
   task automatic t_regs;
      logic [31:0] rd;
      xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0029);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
      xfer(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
      xfer(1'b1, 32'h0000_0000, 32'h0000_004D, rd);
      xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
      chk(rd, 32'h0000_004D);
      $display("test registers done");
   endtask
   task automatic t_video;
      setc(7'h09);
      drive(V, 11'h000, V);
      setc(7'h0B);
      drive(V, 11'h000, V);
      setc(7'h0D);
      drive(V, 11'h000, V);
      setc(7'h4D);
      drive(V, 11'h000, SW);
      setc(7'h08);
      mux(NB, NA);
      setc(7'h0C);
      mux(NA, NB);
      setc(7'h4C);
      mux(NB, NA);
      setc(7'h01);
      drive(V, 11'h000, V);
      setc(7'h00);
      drive(V, 11'h000, NA);
      $display("test video done");
   endtask
   task automatic t_asi;
      logic [31:0] rd;
      setc(7'h12);
      drive(V, 11'h1BC, 20'h6_F000);
      xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0004);
      drive(V, 11'h15A, 20'h1_6800);
      drive(V, 11'h45A, 20'h9_6800);
      drive(V, 11'h25A, 20'h9_6800);
      @(posedge pclk_i);
      det <= 2'h2;
      drive(V, 11'h05A, 20'h1_6800);
      setc(7'h30);
      drive(V, 11'h05A, 20'h0_0000);
      @(posedge pclk_i);
      det <= 2'h1;
      drive(V, 11'h05A, 20'h1_6800);
      @(posedge pclk_i);
      det <= 2'h3;
      drive(V, 11'h05A, 20'h1_6800);
      xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
      chk(rd, 32'h0000_000F);
      $display("test transport done");
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      t_regs;
      t_video;
      t_asi;
      report_and_stop;
   end
   // Watchdog
   initial begin
      #100_000;
      n_errors++;
      report_and_stop;
   end
endmodule

// *** tb/sdipof_rx_model.sv ***
// Downstream receiver model: captures the parallel output bus
// Assumes dout changes just after the pixel clock rising edge
module sdipof_rx_model (
   input  wire logic        pclk_i,
   input  wire logic [19:0] dout_i,
   output logic      [19:0] word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // One word per rising edge, narrow 3G included
   always @(posedge pclk_i) begin
      word_o <= dout_i;
   end
endmodule
